// *** verilog/frc_pkg.sv ***
// Notes on behaviour
// - all arithmetic happens in extended precision
// - extended register value converts to other formats
// - round only after exact intermediate is complete
// - same execution time for any precision
// - forced precision matches single/double-only devices
// - denormal operand normalized, but moved unchanged
// - unnormal normalized; zero mantissa gives normal zero
// - intermediate exponent is 16-bit two's complement
// - store converts exponent to 15-bit biased
// - 67-bit mantissa rounds to 64 bits or fewer
// - register result bits below precision are zero
// - forced precision checks exponent against its range
// - memory destination ignores precision field
// - exact guard/round, sticky ORs all lower bits
// - out-of-range exponent stored as overflow/underflow value; underflow keeps exponent, truncates mantissa
// - infinity result uses maximum exponent, zero mantissa
// - register rounding from field unless instruction forces
// - external destination format sets rounding boundary
// - inexact flag set when rounded differs from exact, except on underflow
// - nearest-even tie leaves even lsb unincremented
// - nearest mode error at most half ulp
// - other modes error at most one ulp
// - too-small result sets underflow flag
// - too-large rounded result sets overflow flag
`default_nettype none
package frc_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] FRC_OFS_CTRL = 8'h00;
    localparam logic [7:0] FRC_OFS_STAT = 8'h04;
    localparam logic [7:0] FRC_OFS_IN_EXP = 8'h08;
    localparam logic [7:0] FRC_OFS_IN_MHI = 8'h0c;
    localparam logic [7:0] FRC_OFS_IN_MLO = 8'h10;
    localparam logic [7:0] FRC_OFS_IN_GRS = 8'h14;
    localparam logic [7:0] FRC_OFS_CMD = 8'h18;
    localparam logic [7:0] FRC_OFS_RES_EXP = 8'h1c;
    localparam logic [7:0] FRC_OFS_RES_MHI = 8'h20;
    localparam logic [7:0] FRC_OFS_RES_MLO = 8'h24;
    localparam int FRC_EXC_INEX = 0;
    localparam int FRC_EXC_UNDERFLOW_FLAG = 1;
    localparam int FRC_EXC_OVERFLOW_FLAG = 2;
    localparam int FRC_STAT_BUSY = 8;
    localparam int FRC_CTRL_ROUNDING_PRECISION_FIELD_LSB = 2;
    localparam int FRC_CMD_FMT_LSB = 2;
    localparam int FRC_CMD_MOVE = 4;
    localparam int FRC_IN_SIGN = 16;
    // ----------------------------------------
    // number formats
    // ----------------------------------------
    localparam logic signed [15:0] FRC_EXT_BIAS = 16'sh3fff;
    localparam logic signed [15:0] FRC_DBL_BIAS = 16'sh03ff;
    localparam logic signed [15:0] FRC_SGL_BIAS = 16'sh007f;
    localparam logic [6:0] FRC_EXT_LSB = 7'h00;
    localparam logic [6:0] FRC_DBL_LSB = 7'h0b;
    localparam logic [6:0] FRC_SGL_LSB = 7'h28;
    localparam logic [14:0] FRC_EXP_INF15 = 15'h7fff;
    typedef enum logic [1:0] {
        FRC_ROUND_TO_NEAREST_MODE = 2'h0,
        FRC_ROUND_TOWARD_ZERO_MODE = 2'h1,
        FRC_ROUND_TOWARD_MINUS_MODE = 2'h2,
        FRC_ROUND_TOWARD_PLUS_MODE = 2'h3
    } frc_mode_e;
    typedef enum logic [1:0] {
        FRC_ROUNDING_PRECISION_FIELD_EXT = 2'h0,
        FRC_ROUNDING_PRECISION_FIELD_SGL = 2'h1,
        FRC_ROUNDING_PRECISION_FIELD_DBL = 2'h2,
        FRC_ROUNDING_PRECISION_FIELD_RSV = 2'h3
    } frc_rounding_precision_field_e;
    typedef enum logic [1:0] {
        FRC_OP_NONE = 2'h0,
        FRC_OP_LOAD = 2'h1,
        FRC_OP_ROUND = 2'h2,
        FRC_OP_STORE = 2'h3
    } frc_op_e;
    typedef enum logic [2:0] {
        FRC_ST_IDLE = 3'h1,
        FRC_ST_NORM = 3'h2,
        FRC_ST_RND = 3'h4
    } frc_state_e;
    typedef struct packed {
        logic sign;
        logic signed [15:0] exp;
        logic [66:0] mant;
    } frc_num_s;
    typedef struct packed {
        frc_state_e st;
        logic [3:0] ctrl;
        logic [2:0] exception_status_byte;
        logic [16:0] in_exp;
        logic [63:0] in_m;
        logic [2:0] in_grs;
        frc_op_e op;
        frc_rounding_precision_field_e fmt;
        logic move;
        frc_num_s w;
        logic [15:0] res_exp;
        logic [31:0] res_hi;
        logic [31:0] res_lo;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } frc_regs_s;
    localparam frc_regs_s FRC_REGS_RST = '{st: FRC_ST_IDLE, op: FRC_OP_NONE,
        fmt: FRC_ROUNDING_PRECISION_FIELD_EXT, default: '0};

    function automatic logic signed [15:0] frc_bias(input frc_rounding_precision_field_e p);
        case (p)
            FRC_ROUNDING_PRECISION_FIELD_SGL: frc_bias = FRC_SGL_BIAS;
            FRC_ROUNDING_PRECISION_FIELD_DBL: frc_bias = FRC_DBL_BIAS;
            default: frc_bias = FRC_EXT_BIAS;
        endcase
    endfunction

    function automatic logic [6:0] frc_lsb(input frc_rounding_precision_field_e p);
        case (p)
            FRC_ROUNDING_PRECISION_FIELD_SGL: frc_lsb = FRC_SGL_LSB;
            FRC_ROUNDING_PRECISION_FIELD_DBL: frc_lsb = FRC_DBL_LSB;
            default: frc_lsb = FRC_EXT_LSB;
        endcase
    endfunction
endpackage
`default_nettype wire

// *** verilog/frc_norm.sv ***
`timescale 1ns/10ps
`default_nettype none
module frc_norm
    import frc_pkg::*;
(
    input wire frc_num_s num_in,
    output frc_num_s num_out,
    output logic zero_out
);
    logic [6:0] lz;
    logic found;

    // ----------------------------------------
    // leading-zero count and left shift
    // ----------------------------------------
    always_comb begin
        lz = 7'h00;
        found = 1'b0;
        for (int i = 66; i >= 0; i--) begin
            if (!found) begin
                if (num_in.mant[i]) begin
                    found = 1'b1;
                end else begin
                    lz = lz + 7'h01;
                end
            end
        end
        zero_out = !found;
        num_out.sign = num_in.sign;
        num_out.mant = num_in.mant << lz;
        num_out.exp = num_in.exp - $signed({9'h000, lz});
    end
endmodule // frc_norm
`default_nettype wire

// *** verilog/frc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module frc_top
    import frc_pkg::*;
(
    input wire logic CLOCK_IN,
    input wire logic ARST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT
);
    frc_regs_s st_r;
    frc_regs_s st_nxt;
    frc_num_s conv;
    frc_num_s normed;
    logic norm_zero;
    logic setup;
    logic wr;
    logic hit;
    logic wr_cmd_go;
    logic busy;
    logic rnd_act;
    frc_rounding_precision_field_e rounding_precision_field;
    frc_mode_e mode;
    logic signed [15:0] bias;
    logic signed [15:0] emin;
    logic [6:0] lsb_pos;
    logic [66:0] sh;
    logic [66:0] low_mask;
    logic [63:0] keep;
    logic g;
    logic r;
    logic s;
    logic lsb;
    logic inc;
    logic [64:0] sum;
    logic [63:0] m_r;
    logic signed [15:0] e_r;
    logic underflow_flag;
    logic ovf;
    logic inf;
    logic zero_res;
    logic [63:0] m_out;
    logic signed [15:0] e_out;
    logic [14:0] eb15;
    logic [7:0] eb8;
    logic [10:0] eb11;
    logic [63:0] dbl_word;
    logic [7:0] e8;
    logic [10:0] e11;

    assign busy = st_r.st != FRC_ST_IDLE;
    assign PRDATA_OUT = st_r.prdata;
    assign PREADY_OUT = st_r.pready;
    assign PSLVERR_OUT = st_r.pslverr;

    // ----------------------------------------
    // operand conversion to extended
    // ----------------------------------------
    always_comb begin
        e8 = st_r.in_m[30:23];
        e11 = st_r.in_m[62:52];
        conv.sign = st_r.in_exp[FRC_IN_SIGN];
        conv.exp = $signed(st_r.in_exp[15:0]);
        conv.mant = {st_r.in_m, st_r.in_grs};
        if (st_r.op == FRC_OP_LOAD && st_r.fmt == FRC_ROUNDING_PRECISION_FIELD_SGL) begin
            conv.sign = st_r.in_m[31];
            conv.exp = (e8 == 8'h00) ? 16'sd1 - FRC_SGL_BIAS
                : $signed({8'h00, e8}) - FRC_SGL_BIAS;
            conv.mant = {e8 != 8'h00, st_r.in_m[22:0], 43'h0};
        end else if (st_r.op == FRC_OP_LOAD && st_r.fmt == FRC_ROUNDING_PRECISION_FIELD_DBL) begin
            conv.sign = st_r.in_m[63];
            conv.exp = (e11 == 11'h000) ? 16'sd1 - FRC_DBL_BIAS
                : $signed({5'h00, e11}) - FRC_DBL_BIAS;
            conv.mant = {e11 != 11'h000, st_r.in_m[51:0], 14'h0};
        end
    end

    frc_norm u_norm (
        .num_in(conv),
        .num_out(normed),
        .zero_out(norm_zero)
    );

    // ----------------------------------------
    // range control and rounding
    // ----------------------------------------
    always_comb begin
        mode = frc_mode_e'(st_r.ctrl[1:0]);
        rounding_precision_field = frc_rounding_precision_field_e'(st_r.ctrl[FRC_CTRL_ROUNDING_PRECISION_FIELD_LSB +: 2]);
        if (st_r.op == FRC_OP_STORE || st_r.fmt != FRC_ROUNDING_PRECISION_FIELD_EXT) begin
            rounding_precision_field = st_r.fmt;
        end
        bias = frc_bias(rounding_precision_field);
        emin = 16'sd1 - bias;
        lsb_pos = frc_lsb(rounding_precision_field);
        sh = st_r.w.mant >> lsb_pos;
        low_mask = (67'h1 << lsb_pos) - 67'h1;
        keep = ~((64'h1 << lsb_pos) - 64'h1);
        g = sh[2];
        r = sh[1];
        s = sh[0] | (|(st_r.w.mant & low_mask));
        lsb = sh[3];
        case (mode)
            FRC_ROUND_TO_NEAREST_MODE: inc = g & (r | s | lsb);
            FRC_ROUND_TOWARD_MINUS_MODE: inc = st_r.w.sign & (g | r | s);
            FRC_ROUND_TOWARD_PLUS_MODE: inc = !st_r.w.sign & (g | r | s);
            default: inc = 1'b0;
        endcase
        sum = {1'b0, st_r.w.mant[66:3] & keep}
            + (inc ? (65'h1 << lsb_pos) : 65'h0);
        m_r = sum[64] ? {1'b1, 63'h0} : sum[63:0];
        e_r = sum[64] ? st_r.w.exp + 16'sd1 : st_r.w.exp;
        zero_res = st_r.w.mant == 67'h0;
        underflow_flag = !zero_res && (st_r.w.exp < emin);
        ovf = !zero_res && !underflow_flag && (e_r > bias);
        inf = mode == FRC_ROUND_TO_NEAREST_MODE
            || (mode == FRC_ROUND_TOWARD_MINUS_MODE && st_r.w.sign)
            || (mode == FRC_ROUND_TOWARD_PLUS_MODE && !st_r.w.sign);
        m_out = m_r;
        e_out = e_r;
        if (underflow_flag) begin
            m_out = st_r.w.mant[66:3] & keep;
            e_out = st_r.w.exp;
        end else if (ovf) begin
            m_out = inf ? 64'h0 : keep;
            e_out = bias;
        end
        eb15 = 15'(e_out + FRC_EXT_BIAS);
        eb8 = 8'(e_out + FRC_SGL_BIAS);
        eb11 = 11'(e_out + FRC_DBL_BIAS);
        if (zero_res) begin
            eb15 = 15'h0;
            eb8 = 8'h00;
            eb11 = 11'h000;
        end else if (ovf && inf) begin
            eb15 = FRC_EXP_INF15;
            eb8 = 8'hff;
            eb11 = 11'h7ff;
        end
        dbl_word = {st_r.w.sign, eb11, m_out[62:11]};
    end

    // ----------------------------------------
    // apb slave and sequencing
    // ----------------------------------------
    assign setup = PSEL_IN && !PENABLE_IN;
    assign wr = PSEL_IN && PENABLE_IN && st_r.pready && PWRITE_IN;
    assign wr_cmd_go = wr && PADDR_IN == FRC_OFS_CMD && !busy
        && PWDATA_IN[1:0] != FRC_OP_NONE;
    assign rnd_act = st_r.st == FRC_ST_RND && st_r.op != FRC_OP_LOAD;

    always_comb begin
        st_nxt = st_r;
        hit = 1'b1;
        st_nxt.pready = setup;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata = 32'h0;
        case (PADDR_IN)
            FRC_OFS_CTRL: st_nxt.prdata = {28'h0, st_r.ctrl};
            FRC_OFS_STAT: st_nxt.prdata = {23'h0, busy, 5'h00, st_r.exception_status_byte};
            FRC_OFS_IN_EXP: st_nxt.prdata = {15'h0, st_r.in_exp};
            FRC_OFS_IN_MHI: st_nxt.prdata = st_r.in_m[63:32];
            FRC_OFS_IN_MLO: st_nxt.prdata = st_r.in_m[31:0];
            FRC_OFS_IN_GRS: st_nxt.prdata = {29'h0, st_r.in_grs};
            FRC_OFS_CMD: st_nxt.prdata = {27'h0, st_r.move, st_r.fmt, st_r.op};
            FRC_OFS_RES_EXP: st_nxt.prdata = {16'h0, st_r.res_exp};
            FRC_OFS_RES_MHI: st_nxt.prdata = st_r.res_hi;
            FRC_OFS_RES_MLO: st_nxt.prdata = st_r.res_lo;
            default: hit = 1'b0;
        endcase
        if (!setup) begin
            st_nxt.prdata = st_r.prdata;
        end else if (!hit) begin
            st_nxt.pslverr = 1'b1;
        end
        if (wr && !busy) begin
            case (PADDR_IN)
                FRC_OFS_CTRL: st_nxt.ctrl = PWDATA_IN[3:0];
                FRC_OFS_IN_EXP: st_nxt.in_exp = PWDATA_IN[16:0];
                FRC_OFS_IN_MHI: st_nxt.in_m[63:32] = PWDATA_IN;
                FRC_OFS_IN_MLO: st_nxt.in_m[31:0] = PWDATA_IN;
                FRC_OFS_IN_GRS: st_nxt.in_grs = PWDATA_IN[2:0];
                default: ;
            endcase
        end
        // exception byte: write one to clear, a same-cycle set wins
        if (wr && PADDR_IN == FRC_OFS_STAT) begin
            st_nxt.exception_status_byte = st_r.exception_status_byte & ~PWDATA_IN[2:0];
        end
        if (wr_cmd_go) begin
            st_nxt.op = frc_op_e'(PWDATA_IN[1:0]);
            st_nxt.fmt = frc_rounding_precision_field_e'(PWDATA_IN[FRC_CMD_FMT_LSB +: 2]);
            st_nxt.move = PWDATA_IN[FRC_CMD_MOVE];
        end
        case (st_r.st)
            FRC_ST_IDLE: begin
                if (wr_cmd_go) begin
                    st_nxt.st = FRC_ST_NORM;
                end
            end
            FRC_ST_NORM: begin
                st_nxt.st = FRC_ST_RND;
                if (st_r.op == FRC_OP_LOAD && st_r.move) begin
                    st_nxt.w = conv;
                end else if (norm_zero) begin
                    st_nxt.w = '{sign: conv.sign, exp: -FRC_EXT_BIAS, mant: 67'h0};
                end else begin
                    st_nxt.w = normed;
                end
            end
            FRC_ST_RND: begin
                st_nxt.st = FRC_ST_IDLE;
                if (st_r.op == FRC_OP_LOAD) begin
                    st_nxt.res_exp = {st_r.w.sign, 15'(st_r.w.exp + FRC_EXT_BIAS)};
                    if (st_r.w.mant == 67'h0) begin
                        st_nxt.res_exp[14:0] = 15'h0;
                    end
                    st_nxt.res_hi = st_r.w.mant[66:35];
                    st_nxt.res_lo = st_r.w.mant[34:3];
                end else begin
                    st_nxt.exception_status_byte = st_nxt.exception_status_byte
                        | {ovf, underflow_flag, (!underflow_flag && (g | r | s)) || ovf};
                    st_nxt.res_exp = {st_r.w.sign, eb15};
                    st_nxt.res_hi = m_out[63:32];
                    st_nxt.res_lo = m_out[31:0];
                    if (st_r.op == FRC_OP_STORE && rounding_precision_field == FRC_ROUNDING_PRECISION_FIELD_SGL) begin
                        st_nxt.res_hi = 32'h0;
                        st_nxt.res_lo = {st_r.w.sign, eb8, m_out[62:40]};
                    end else if (st_r.op == FRC_OP_STORE && rounding_precision_field == FRC_ROUNDING_PRECISION_FIELD_DBL) begin
                        st_nxt.res_hi = dbl_word[63:32];
                        st_nxt.res_lo = dbl_word[31:0];
                    end
                end
            end
            default: st_nxt.st = FRC_ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            st_r <= FRC_REGS_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!ARST_N_IN);

    sequence s_cmd_go;
        wr_cmd_go;
    endsequence
    sequence s_two_steps;
        st_r.st == FRC_ST_NORM ##1 st_r.st == FRC_ST_RND ##1 !busy;
    endsequence

    a_fixed_latency: assert property (s_cmd_go |=> s_two_steps)
        else $error("command latency is not fixed");
    a_inexact_flag: assert property (rnd_act && !underflow_flag && (g || r || s)
        |=> st_r.exception_status_byte[FRC_EXC_INEX])
        else $error("inexact flag not set");
    a_tie_even: assert property (rnd_act && mode == FRC_ROUND_TO_NEAREST_MODE
        && g && !r && !s && !lsb |-> !inc)
        else $error("tie to even incremented");
    a_underflow_flag_flag: assert property (rnd_act && underflow_flag
        |-> !ovf ##1 st_r.exception_status_byte[FRC_EXC_UNDERFLOW_FLAG] && !busy)
        else $error("underflow flag wrong");
    a_overflow_flag_flag: assert property (rnd_act && ovf |=> st_r.exception_status_byte[FRC_EXC_OVERFLOW_FLAG])
        else $error("overflow flag not set");
    a_inf_result: assert property (rnd_act && ovf && inf && st_r.op == FRC_OP_ROUND
        |=> st_r.res_exp[14:0] == FRC_EXP_INF15 && st_r.res_hi == 32'h0
        && st_r.res_lo == 32'h0)
        else $error("infinity result malformed");
    a_low_zero: assert property (rnd_act && st_r.op == FRC_OP_ROUND
        |=> ({st_r.res_hi, st_r.res_lo} & ~$past(keep)) == 64'h0)
        else $error("bits below precision not zero");
    a_zero_norm: assert property (st_r.st == FRC_ST_NORM && !st_r.move
        && conv.mant == 67'h0 |=> st_r.w.mant == 67'h0 && st_r.w.exp == -FRC_EXT_BIAS)
        else $error("zero operand not normal zero");
    a_denorm_keep: assert property (st_r.st == FRC_ST_NORM && st_r.op == FRC_OP_LOAD
        && st_r.move |=> st_r.w == $past(conv))
        else $error("moved operand altered");
    a_mem_rounding_precision_field: assert property (rnd_act && st_r.op == FRC_OP_STORE
        |-> rounding_precision_field == st_r.fmt || st_r.fmt == FRC_ROUNDING_PRECISION_FIELD_RSV)
        else $error("store used precision field");
endmodule // frc_top
`default_nettype wire

// *** tb/frc_apb_master.sv ***
`timescale 1ns/10ps
`default_nettype none
module frc_apb_master (
    input wire logic clk_in,
    input wire logic pready_in,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [7:0] paddr_out,
    output logic [31:0] pwdata_out
);
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 8'h00;
        pwdata_out = 32'h0;
    end
    // ----------------------------------------
    // one apb transfer, held until pready is sampled
    // ----------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic ok);
        int n;
        @(posedge clk_in);
        psel_out <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out <= wr;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_in !== 1'b1 && n < 32);
        ok = (pready_in === 1'b1);
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        // released lines must not keep the old value
        paddr_out <= ~a;
        pwdata_out <= ~d;
    endtask
endmodule // frc_apb_master
`default_nettype wire

// *** tb/tb_fpu_rounding_range_control.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_fpu_rounding_range_control
    import frc_pkg::*;
;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] m;
        logic e;
    } frc_note_s;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] seed = 32'h2c6d;
    int n_mismatch = 0;
    int tests_run = 0;
    frc_note_s notes[$];
    frc_note_s nt;

    always #20 clk = ~clk;

    frc_top u_frc_top (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
    frc_apb_master u_frc_apb_master (.clk_in(clk), .pready_in(pready), .psel_out(psel),
        .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));

    // ----------------------------------------
    // read monitor and verdict
    // ----------------------------------------
    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (notes.size() == 0) begin
                n_mismatch++;
                $display("CHECK FAILED read %h expected none seen %h", paddr, prdata);
            end else begin
                nt = notes.pop_front();
                tests_run++;
                if ((prdata & nt.m) !== (nt.d & nt.m) || pslverr !== nt.e) begin
                    n_mismatch++;
                    $display("CHECK FAILED read %h expected %h/%b seen %h/%b", nt.a,
                        nt.d & nt.m, nt.e, prdata & nt.m, pslverr);
                end
            end
        end
    end

    task automatic results;
        $display("counts: %0d checks, %0d mismatches", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ok;
        u_frc_apb_master.xfer(1'b1, a, d, ok);
        if (!ok) begin
            n_mismatch++;
            $display("CHECK FAILED pready expected 1 seen 0");
            results();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
        input logic e);
        logic ok;
        notes.push_back('{a, d, m, e});
        u_frc_apb_master.xfer(1'b0, a, seed, ok);
        if (!ok) begin
            n_mismatch++;
            $display("CHECK FAILED pready expected 1 seen 0");
            results();
        end
    endtask

    // clear flags, issue command, busy must show while it runs
    task automatic run(input logic [4:0] cmd);
        wr(FRC_OFS_STAT, 32'h7);
        wr(FRC_OFS_CMD, {27'h0, cmd});
        rd(FRC_OFS_STAT, 32'h100, 32'h107, 1'b0);
    endtask

    task automatic t(input string nm, input logic s, input logic [15:0] x,
        input logic [63:0] mt, input logic [2:0] g, input logic [3:0] c,
        input logic [4:0] cmd, input logic [15:0] ex, input logic [15:0] xm,
        input logic [31:0] hi, input logic [31:0] lo, input logic [31:0] dm,
        input logic [2:0] st);
        wr(FRC_OFS_CTRL, {28'h0, c});
        wr(FRC_OFS_IN_EXP, {15'h0, s, x});
        wr(FRC_OFS_IN_MHI, mt[63:32]);
        wr(FRC_OFS_IN_MLO, mt[31:0]);
        wr(FRC_OFS_IN_GRS, {29'h0, g});
        run(5'h01);
        run(cmd);
        rd(FRC_OFS_RES_EXP, {16'h0, ex}, {16'h0, xm}, 1'b0);
        rd(FRC_OFS_RES_MHI, hi, dm, 1'b0);
        rd(FRC_OFS_RES_MLO, lo, (dm == 32'h0) ? 32'h0 : 32'hffff_ffff, 1'b0);
        rd(FRC_OFS_STAT, {29'h0, st}, 32'h107, 1'b0);
        $display("test %s done", nm);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        logic [63:0] mt;
        logic s;
        int k;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rd(FRC_OFS_CTRL, 32'h0, 32'hffff_ffff, 1'b0);
        rd(FRC_OFS_STAT, 32'h0, 32'hffff_ffff, 1'b0);
        rd(FRC_OFS_RES_EXP, 32'h0, 32'hffff_ffff, 1'b0);
        rd(8'h40, 32'h0, 32'hffff_ffff, 1'b1);
        $display("test reset done");
        t("tie_even", 1'b0, 16'h0, 64'h8000_0000_0000_0000, 3'b100, 4'h0, 5'h02,
            16'h3fff, 16'hffff, 32'h8000_0000, 32'h0, 32'hffff_ffff, 3'b001);
        t("tie_odd", 1'b0, 16'h0, 64'h8000_0000_0000_0001, 3'b100, 4'h0, 5'h02,
            16'h3fff, 16'hffff, 32'h8000_0000, 32'h2, 32'hffff_ffff, 3'b001);
        for (k = 0; k < 8; k++) begin
            s = k[2];
            t("mode", s, 16'h0, 64'h8000_0000_0000_0001, 3'b010, {2'h0, k[1:0]}, 5'h02,
                {s, 15'h3fff}, 16'hffff, 32'h8000_0000,
                32'h1 + {31'h0, (k[1:0] == 2'h3 && !s) || (k[1:0] == 2'h2 && s)},
                32'hffff_ffff, 3'b001);
        end
        for (k = 0; k < 3; k++) begin
            seed = xs(seed);
            mt[63:32] = seed | 32'h8000_0000;
            seed = xs(seed);
            mt[31:0] = seed;
            t("exact", 1'b0, 16'h0, mt, 3'b000, 4'h0, 5'h02, 16'h3fff, 16'hffff,
                mt[63:32], mt[31:0], 32'hffff_ffff, 3'b000);
        end
        t("sgl_force", 1'b0, 16'h0, 64'h8000_0080_0000_0001, 3'b000, 4'h0, 5'h06,
            16'h3fff, 16'hffff, 32'h8000_0100, 32'h0, 32'hffff_ffff, 3'b001);
        t("dbl_ctrl", 1'b0, 16'h0, 64'h8000_0000_0000_0400, 3'b000, 4'h8, 5'h02,
            16'h3fff, 16'hffff, 32'h8000_0000, 32'h0, 32'hffff_ffff, 3'b001);
        t("unnorm", 1'b0, 16'h0, 64'h4000_0000_0000_0000, 3'b000, 4'h0, 5'h02,
            16'h3ffe, 16'hffff, 32'h8000_0000, 32'h0, 32'hffff_ffff, 3'b000);
        t("zero", 1'b0, 16'h0, 64'h0, 3'b000, 4'h0, 5'h02,
            16'h0, 16'hffff, 32'h0, 32'h0, 32'hffff_ffff, 3'b000);
        t("st_sgl", 1'b0, 16'h0, 64'h8000_0080_0000_0000, 3'b000, 4'h8, 5'h07,
            16'h0, 16'h0, 32'h0, 32'h3f80_0000, 32'hffff_ffff, 3'b001);
        t("st_dbl", 1'b1, 16'h0, 64'h8000_0000_0000_0000, 3'b000, 4'h4, 5'h0b,
            16'h0, 16'h0, 32'hbff0_0000, 32'h0, 32'hffff_ffff, 3'b000);
        t("overflow_flag", 1'b0, 16'd200, 64'h8000_0000_0000_0000, 3'b000, 4'h0, 5'h06,
            16'h7fff, 16'hffff, 32'h0, 32'h0, 32'h7fff_ffff, 3'b101);
        t("underflow_flag", 1'b0, 16'hff38, 64'h8000_0000_0000_0000, 3'b000, 4'h0, 5'h06,
            16'h3f37, 16'hffff, 32'h8000_0000, 32'h0, 32'hffff_ffff, 3'b010);
        t("overflow_flag_max", 1'b0, 16'd200, 64'h8000_0000_0000_0000, 3'b000, 4'h1, 5'h06,
            16'h407e, 16'hffff, 32'hffff_ff00, 32'h0, 32'hffff_ffff, 3'b101);
        t("ld_sgl", 1'b0, 16'h0, 64'h0000_0000_c040_0000, 3'b000, 4'h0, 5'h05,
            16'hc000, 16'hffff, 32'hc000_0000, 32'h0, 32'hffff_ffff, 3'b000);
        t("ld_dbl", 1'b0, 16'h0, 64'h4008_0000_0000_0000, 3'b000, 4'h0, 5'h09,
            16'h4000, 16'hffff, 32'hc000_0000, 32'h0, 32'hffff_ffff, 3'b000);
        t("move_den", 1'b0, 16'hc001, 64'h0000_0001_0000_0000, 3'b000, 4'h0, 5'h11,
            16'h0000, 16'hffff, 32'h0000_0001, 32'h0, 32'hffff_ffff, 3'b000);
        k = 0;
        while (notes.size() != 0 && k < 16) begin
            @(posedge clk);
            k++;
        end
        if (notes.size() != 0) begin
            n_mismatch++;
            $display("CHECK FAILED read queue expected 0 seen %0d", notes.size());
        end
        results();
    end
endmodule // tb_fpu_rounding_range_control
`default_nettype wire
